// ==== testbench/dbt_asserts.sv ====
`timescale 1ns/1ps
module dbt_asserts #(
  parameter FULL_TRACE = 1,
  parameter NUM_PC = 4
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register bus.
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire cpu_supervisor,
  // Core side.
  input wire [3:0] cpu_pst,
  input wire [3:0] cpu_debug_trace_data_bus,
  input wire [2:0] cpu_irq_level,
  input wire cpu_halt,
  input wire cpu_debug_irq,
  input wire irq_allow,
  input wire irq,
  // Trace port.
  input wire [3:0] processor_status_bus,
  input wire [3:0] debug_trace_data_bus,
  input wire trace_clock_out,
  input wire all_status_high
);
  logic [3:0] live_reg;
  wire live;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Counts edges after reset so trace checks skip the internal reset stretch.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      live_reg <= 4'h0;
    else
      live_reg <= {live_reg[2:0], 1'b1};
  end
  assign live = live_reg[3];

  AST_ALL_STATUS: assert property (all_status_high == &processor_status_bus)
    else $error("all-status output differs from the AND of the status bus");
  AST_HALT_CODE: assert property (live && cpu_halt && $past(cpu_halt)
    |-> processor_status_bus == 4'hf)
    else $error("status bus not all ones while halted");
  AST_RUN_TRACE: assert property (live && !cpu_halt && !$past(cpu_halt)
    |-> processor_status_bus == $past(cpu_pst))
    else $error("status bus does not follow the core one cycle later");
  AST_DATA_TRACE: assert property (live |-> debug_trace_data_bus == $past(cpu_debug_trace_data_bus))
    else $error("trace data bus does not follow the core one cycle later");
  AST_TRACE_CLK: assert property (trace_clock_out == (FULL_TRACE != 0))
    else $error("trace clock not in antiphase with the core clock");
  AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus access not answered in the second cycle");
  AST_USER_READ: assert property (!cpu_supervisor && avs_read && !avs_waitrequest
    |-> avs_readdata == 32'h0)
    else $error("read outside supervisor mode returned data");
  AST_DBG_PULSE: assert property (cpu_debug_irq |=> !cpu_debug_irq)
    else $error("debug interrupt longer than one cycle");
  AST_CRIT_PASS: assert property (cpu_irq_level == 3'h7 |-> irq_allow)
    else $error("top level interrupt blocked");

  // Main scenarios.
  COV_HALT: cover property ($rose(cpu_halt));
  COV_DBG: cover property (cpu_debug_irq);
  COV_IRQ: cover property ($rose(irq));
  COV_BLOCK: cover property (!irq_allow);
endmodule // dbt_asserts

// ==== testbench/dbt_tool_model.sv ====
`timescale 1ns/1ps
module dbt_tool (
  // Serial pins.
  output logic debug_serial_clock,
  output logic debug_serial_in,
  input wire debug_serial_out
);
  // The serial clock stands low between frames.
  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b0;
  end

  // Sends one 40-bit frame MSB first and collects the 32 answer bits.
  task frame(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
             output logic [31:0] rd);
    logic [39:0] f;
    integer i;
    begin
      f = {wr, 3'h0, idx, wd};
      rd = 32'h0;
      #10; // Step off the core clock edges so pin changes never race the sampler.
      for (i = 39; i >= 0; i = i - 1) begin
        debug_serial_in = f[i];
        #160 debug_serial_clock = 1'b1;
        if (i < 32)
          rd[i] = debug_serial_out;
        #160 debug_serial_clock = 1'b0;
      end
      debug_serial_in = ~f[0]; // A released line shows the inverse of its last bit.
      #2000;
    end
  endtask
endmodule // dbt_tool

// ==== testbench/dbt_top_tb.sv ====
`timescale 1ns/1ps
module dbt_top_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic cpu_supervisor = 1'b1;
  logic cpu_addr_valid = 1'b0;
  logic cpu_pc_valid = 1'b0;
  logic cpu_debug_rte = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [31:0] cpu_data = 32'h0;
  logic [31:0] cpu_pc = 32'h0;
  logic [3:0] cpu_pst = 4'h0;
  logic [3:0] cpu_debug_trace_data_bus = 4'h0;
  logic [2:0] cpu_irq_level = 3'h0;
  wire [31:0] avs_readdata;
  wire [3:0] processor_status_bus, debug_trace_data_bus;
  wire avs_waitrequest, cpu_halt, cpu_debug_irq, irq_allow, irq, all_status_high;
  wire debug_serial_clock, debug_serial_in, debug_serial_out;
  integer n_errors = 0;
  integer checked = 0;
  integer i;
  logic [31:0] d;

  dbt_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_supervisor(cpu_supervisor), .cpu_addr_valid(cpu_addr_valid), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .cpu_pc_valid(cpu_pc_valid), .cpu_pc(cpu_pc), .cpu_pst(cpu_pst),
    .cpu_debug_trace_data_bus(cpu_debug_trace_data_bus), .cpu_irq_level(cpu_irq_level), .cpu_debug_rte(cpu_debug_rte),
    .cpu_halt(cpu_halt), .cpu_debug_irq(cpu_debug_irq), .irq_allow(irq_allow),
    .debug_serial_clock(debug_serial_clock), .debug_serial_in(debug_serial_in),
    .debug_serial_out(debug_serial_out), .processor_status_bus(processor_status_bus),
    .debug_trace_data_bus(debug_trace_data_bus), .trace_clock_out(),
    .all_status_high(all_status_high), .irq(irq));
  dbt_tool tool_u (.debug_serial_clock(debug_serial_clock),
    .debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out));

  // Core clock at 25 MHz.
  always #20 sys_clk = ~sys_clk;

  task test_done();
    begin
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        n_errors = n_errors + 1;
      end
    end
  endtask

  // One bus access, held until waitrequest is seen low.
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    integer n;
    begin
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
        @(posedge sys_clk);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      rd = avs_readdata;
      if (n >= 100) begin
        n_errors = n_errors + 1;
        test_done();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task wr(input logic [5:0] a, input logic [31:0] v);
    logic [31:0] unused;
    bus(1'b1, a, v, unused);
  endtask

  task rdc(input logic [5:0] a, input logic [31:0] want);
    logic [31:0] got;
    begin
      bus(1'b0, a, 32'h0, got);
      chk(got, want);
    end
  endtask

  // Presents one observed bus or program-counter value for one cycle.
  task step(input logic av, input logic [31:0] a, input logic [31:0] dt, input logic [31:0] pc);
    begin
      @(posedge sys_clk);
      cpu_addr_valid <= av;
      cpu_addr <= a;
      cpu_data <= dt;
      cpu_pc_valid <= ~av;
      cpu_pc <= pc;
      @(posedge sys_clk);
      cpu_addr_valid <= 1'b0;
      cpu_pc_valid <= 1'b0;
      @(negedge sys_clk);
    end
  endtask

  // Cuts a hung run short.
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cpu_pst <= 4'h6;
    cpu_debug_trace_data_bus <= 4'h9;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({28'h0, processor_status_bus}, 32'h6);
    chk({28'h0, debug_trace_data_bus}, 32'h9);
    chk({31'h0, all_status_high}, 32'h0);
    $display("test trace done");
    for (i = 0; i < 9; i = i + 1) begin
      rdc(6'(i * 4), 32'h0);
      wr(6'(i * 4), 32'h5a5a5a5a ^ 32'(32'h11111111 * i));
    end
    for (i = 0; i < 9; i = i + 1)
      rdc(6'(i * 4), 32'h5a5a5a5a ^ 32'(32'h11111111 * i));
    rdc(6'h3c, 32'h0);
    cpu_supervisor <= 1'b0;
    wr(6'h00, 32'h00001234);
    rdc(6'h00, 32'h0);
    cpu_supervisor <= 1'b1;
    rdc(6'h00, 32'h5a5a5a5a);
    $display("test registers done");
    tool_u.frame(1'b1, 4'h5, 32'hcafe0001, d);
    rdc(6'h14, 32'hcafe0001);
    tool_u.frame(1'b0, 4'h0, 32'h0, d);
    chk(d, 32'h5a5a5a5a);
    rdc(6'h28, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(6'h2c, 32'h4);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(6'h28, 32'h4);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test serial done");
    wr(6'h20, 32'h000000ff);
    wr(6'h24, 32'h00008004);
    step(1'b0, 32'h0, 32'h0, 32'hcafe0100);
    chk({31'h0, cpu_halt}, 32'h0);
    step(1'b0, 32'h0, 32'h0, 32'hcafe00ee);
    chk({31'h0, cpu_halt}, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk({28'h0, processor_status_bus}, 32'hf);
    chk({31'h0, all_status_high}, 32'h1);
    rdc(6'h30, 32'h2);
    bus(1'b0, 6'h28, 32'h0, d);
    chk({31'h0, d[0]}, 32'h1);
    wr(6'h30, 32'h1);
    @(negedge sys_clk);
    chk({31'h0, cpu_halt}, 32'h0);
    wr(6'h28, 32'h7);
    $display("test halt done");
    wr(6'h00, 32'h00004000);
    wr(6'h04, 32'h0);
    wr(6'h08, 32'h0000beef);
    wr(6'h0c, 32'h0);
    wr(6'h24, 32'h0000d321);
    step(1'b1, 32'h00008000, 32'h0000beef, 32'h0);
    chk({31'h0, cpu_debug_irq}, 32'h0);
    step(1'b1, 32'h00004000, 32'h0, 32'h0);
    chk({31'h0, cpu_debug_irq}, 32'h0);
    step(1'b1, 32'h0, 32'h0000beef, 32'h0);
    chk({31'h0, cpu_debug_irq}, 32'h1);
    rdc(6'h30, 32'h4);
    for (i = 4; i < 8; i = i + 1) begin
      @(posedge sys_clk);
      cpu_irq_level <= 3'(i);
      @(negedge sys_clk);
      chk({31'h0, irq_allow}, 32'(i >= 5));
    end
    @(posedge sys_clk);
    cpu_irq_level <= 3'h4;
    cpu_debug_rte <= 1'b1;
    @(posedge sys_clk);
    cpu_debug_rte <= 1'b0;
    @(negedge sys_clk);
    chk({31'h0, irq_allow}, 32'h1);
    $display("test debug interrupt done");
    test_done();
  end
endmodule // dbt_top_tb

bind dbt_top dbt_asserts #(.FULL_TRACE(FULL_TRACE), .NUM_PC(NUM_PC)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cpu_supervisor(cpu_supervisor), .cpu_pst(cpu_pst), .cpu_debug_trace_data_bus(cpu_debug_trace_data_bus),
  .cpu_irq_level(cpu_irq_level), .cpu_halt(cpu_halt), .cpu_debug_irq(cpu_debug_irq),
  .irq_allow(irq_allow), .irq(irq), .processor_status_bus(processor_status_bus),
  .debug_trace_data_bus(debug_trace_data_bus), .trace_clock_out(trace_clock_out),
  .all_status_high(all_status_high));

// ==== verilog/dbt_regs.vh ====
// Notes on behaviour
// - Nine 32-bit breakpoint registers: address, mask, data, mask, four PC, PC mask.
// - Breakpoint registers read and written by serial tool and by supervisor-mode processor.
// - Triggers combine address, data and PC matches, single level or two-level sequence.
// - A trigger either halts the processor or raises a debug interrupt.
// - During debug interrupt handling, interrupts at critical level still pass.
// - Drive 4-bit processor status bus and 4-bit debug trace data bus.
// - Trace buses update every CPU clock; a trace clock is driven alongside.
// - All-status output is the AND of the four internal status bits, shown on the status bus under full trace.
// - While halted the status bus shows all ones, driving all-status high.
// - Full trace only on large package; serial channel and all-status always present.
`ifndef DBT_REGS_VH
`define DBT_REGS_VH

// Register word indexes; the byte address is four times the index.
`define DBT_IDX_ADDR 4'h0
`define DBT_IDX_ADDR_MASK 4'h1
`define DBT_IDX_DATA 4'h2
`define DBT_IDX_DATA_MASK 4'h3
`define DBT_IDX_PC0 4'h4
`define DBT_IDX_PC_MASK 4'h8
`define DBT_IDX_TRIG_CTRL 4'h9
`define DBT_IDX_STATUS 4'ha
`define DBT_IDX_IRQ_MASK 4'hb
`define DBT_IDX_CORE_CTRL 4'hc

// Trigger control fields.
`define DBT_TC_LVL1_LO 0
`define DBT_TC_LVL2_LO 4
`define DBT_TC_TWO_LEVEL 8
`define DBT_TC_ACTION_IRQ 9
`define DBT_TC_CRIT_LO 12
`define DBT_TC_ENABLE 15

// Status and core control bits.
`define DBT_ST_FIRED 0
`define DBT_ST_LVL1 1
`define DBT_ST_SERIAL 2
`define DBT_CC_GO 0
`define DBT_CC_HALTED 1
`define DBT_CC_EMU 2

// Reset values.
`define DBT_RST_WORD 32'h00000000

// Serial frame layout and timing.
`define DBT_SER_FRAME_BITS 6'd40
`define DBT_SER_HDR_BITS 6'd8
`define DBT_SER_IDLE_CYC 7'd64

`endif

// ==== verilog/dbt_serial.v ====
`timescale 1ns/1ps
`include "dbt_regs.vh"

module dbt_serial (
  // Clock and synchronous reset copy.
  input wire sys_clk,
  input wire rst_sync_n,
  // Serial pins from the debug tool.
  input wire debug_serial_clock,
  input wire debug_serial_in,
  output reg debug_serial_out,
  // Register access requests.
  output reg req_write,
  output reg req_read,
  output reg [3:0] req_idx,
  output reg [31:0] req_wdata,
  input wire [31:0] rd_data
);

  reg [1:0] clk_sync_reg;
  reg [1:0] din_sync_reg;
  reg clk_last_reg;
  reg [5:0] bit_cnt_reg;
  reg [6:0] idle_cnt_reg;
  reg [39:0] shin_reg;
  reg [31:0] shout_reg;
  reg is_read_reg;
  wire rise;
  wire fall;
  wire [39:0] shin_next;

  // Edge detection reads only the second synchroniser stage.
  assign rise = clk_sync_reg[1] & ~clk_last_reg;
  assign fall = ~clk_sync_reg[1] & clk_last_reg;
  assign shin_next = {shin_reg[38:0], din_sync_reg[1]};

  // Pin synchronisers.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_sync_reg <= 2'h0;
      din_sync_reg <= 2'h0;
      clk_last_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], debug_serial_clock};
      din_sync_reg <= {din_sync_reg[0], debug_serial_in};
      clk_last_reg <= clk_sync_reg[1];
    end
  end

  // Frame shifter: header then data, a quiet clock ends a partial frame.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bit_cnt_reg <= 6'h0;
      idle_cnt_reg <= 7'h0;
      shin_reg <= 40'h0;
      shout_reg <= 32'h0;
      is_read_reg <= 1'b0;
      req_write <= 1'b0;
      req_read <= 1'b0;
      req_idx <= 4'h0;
      req_wdata <= 32'h0;
      debug_serial_out <= 1'b0;
    end else begin
      req_write <= 1'b0;
      req_read <= 1'b0;
      if (rise) begin
        idle_cnt_reg <= 7'h0;
        shin_reg <= shin_next;
        if (bit_cnt_reg == `DBT_SER_FRAME_BITS - 6'd1) begin
          bit_cnt_reg <= 6'h0;
          if (!is_read_reg) begin
            req_write <= 1'b1;
            req_wdata <= shin_next[31:0];
          end
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 6'd1;
        end
        if (bit_cnt_reg == `DBT_SER_HDR_BITS - 6'd1) begin
          is_read_reg <= ~shin_next[7];
          req_idx <= shin_next[3:0];
          req_read <= ~shin_next[7];
        end
      end else if (idle_cnt_reg == `DBT_SER_IDLE_CYC) begin
        bit_cnt_reg <= 6'h0;
        is_read_reg <= 1'b0;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 7'd1;
      end
      // Read data is loaded one cycle after the header and sent MSB first.
      if (req_read) begin
        shout_reg <= {rd_data[30:0], 1'b0};
        debug_serial_out <= rd_data[31];
      end else if (fall && is_read_reg && bit_cnt_reg > `DBT_SER_HDR_BITS) begin
        debug_serial_out <= shout_reg[31];
        shout_reg <= {shout_reg[30:0], 1'b0};
      end
    end
  end

endmodule // dbt_serial

// ==== verilog/dbt_top.v ====
`timescale 1ns/1ps
`include "dbt_regs.vh"

module dbt_top #(
  parameter FULL_TRACE = 1,
  parameter NUM_PC = 4
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Avalon-MM register slave.
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Core privilege for bus access.
  input wire cpu_supervisor,
  // Core bus and program counter observation.
  input wire cpu_addr_valid,
  input wire [31:0] cpu_addr,
  input wire [31:0] cpu_data,
  input wire cpu_pc_valid,
  input wire [31:0] cpu_pc,
  // Core trace sources.
  input wire [3:0] cpu_pst,
  input wire [3:0] cpu_debug_trace_data_bus,
  // Core interrupt handling.
  input wire [2:0] cpu_irq_level,
  input wire cpu_debug_rte,
  output reg cpu_halt,
  output reg cpu_debug_irq,
  output wire irq_allow,
  // Debug serial channel.
  input wire debug_serial_clock,
  input wire debug_serial_in,
  output wire debug_serial_out,
  // Trace port.
  output wire [3:0] processor_status_bus,
  output wire [3:0] debug_trace_data_bus,
  output wire trace_clock_out,
  output wire all_status_high,
  // Interrupt to the system.
  output wire irq
);

  // Trigger sequencer states.
  localparam TS_IDLE = 1'b0;
  localparam TS_LVL2 = 1'b1;

  // Reset copy, breakpoint bank and control registers.
  reg [1:0] rst_sync_reg;
  wire rst_sync_n;
  reg [31:0] bp_reg [0:8];
  reg [15:0] trig_ctrl_reg;
  reg [2:0] status_reg;
  reg [2:0] status_next;
  reg [2:0] irq_mask_reg;
  reg ack_reg;
  reg tstate_reg;
  reg tstate_next;
  reg emu_reg;
  // Comparator results and sequencer decisions.
  reg fire;
  reg lvl1_hit;
  reg lvl2_hit;
  reg addr_hit;
  reg data_hit;
  reg pc_hit;
  // Serial channel requests and bus decode nets.
  wire ser_write;
  wire ser_read;
  wire [3:0] ser_idx;
  wire [31:0] ser_wdata;
  wire [31:0] ser_rdata;
  wire bus_write;
  wire [3:0] bus_idx;
  wire bus_ok;
  wire go_cmd;
  integer i;
  integer j;

  // Masked equality: a set mask bit removes that bit from the compare.
  function masked_match;
    input [31:0] seen;
    input [31:0] want;
    input [31:0] mask;
    begin
      masked_match = (((seen ^ want) & ~mask) == 32'h0);
    end
  endfunction

  // A level condition holds when at least one source is enabled and all enabled ones hit.
  function level_cond;
    input [2:0] en;
    input ah;
    input dh;
    input ph;
    begin
      level_cond = (|en) & (~en[0] | ah) & (~en[1] | dh) & (~en[2] | ph);
    end
  endfunction

  // Register read multiplexer shared by bus and serial channel.
  function [31:0] reg_read;
    input [3:0] idx;
    input [31:0] r0;
    input [31:0] r1;
    input [31:0] r2;
    input [31:0] r3;
    input [31:0] r4;
    input [31:0] r5;
    input [31:0] r6;
    input [31:0] r7;
    input [31:0] r8;
    input [15:0] tc;
    input [2:0] st;
    input [2:0] im;
    input [2:0] cc;
    begin
      case (idx)
        4'h0: reg_read = r0;
        4'h1: reg_read = r1;
        4'h2: reg_read = r2;
        4'h3: reg_read = r3;
        4'h4: reg_read = r4;
        4'h5: reg_read = r5;
        4'h6: reg_read = r6;
        4'h7: reg_read = r7;
        4'h8: reg_read = r8;
        `DBT_IDX_TRIG_CTRL: reg_read = {16'h0, tc};
        `DBT_IDX_STATUS: reg_read = {29'h0, st};
        `DBT_IDX_IRQ_MASK: reg_read = {29'h0, im};
        `DBT_IDX_CORE_CTRL: reg_read = {29'h0, cc};
        default: reg_read = 32'h0;
      endcase
    end
  endfunction

  // Reset release through two flip-flops.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_reg[1];

  // Bus access: one wait cycle, user-mode requests complete with no effect.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign bus_idx = avs_address[5:2];
  assign bus_ok = cpu_supervisor;
  assign bus_write = avs_write & ack_reg & bus_ok;
  assign go_cmd = (bus_write && bus_idx == `DBT_IDX_CORE_CTRL && avs_writedata[`DBT_CC_GO]) ||
                  (ser_write && ser_idx == `DBT_IDX_CORE_CTRL && ser_wdata[`DBT_CC_GO]);

  // Acknowledge and read data registers.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      // Read data is captured in the request cycle and stands while waitrequest is low.
      if (avs_read && !ack_reg) begin
        avs_readdata <= bus_ok ? reg_read(bus_idx, bp_reg[0], bp_reg[1], bp_reg[2], bp_reg[3],
          bp_reg[4], bp_reg[5], bp_reg[6], bp_reg[7], bp_reg[8], trig_ctrl_reg, status_reg,
          irq_mask_reg, {emu_reg, cpu_halt, 1'b0}) : 32'h0;
      end
    end
  end

  // Serial reads see the same register map as the bus, without the privilege gate.
  assign ser_rdata = reg_read(ser_idx, bp_reg[0], bp_reg[1], bp_reg[2], bp_reg[3],
    bp_reg[4], bp_reg[5], bp_reg[6], bp_reg[7], bp_reg[8], trig_ctrl_reg, status_reg,
    irq_mask_reg, {emu_reg, cpu_halt, 1'b0});

  // Breakpoint and control writes; a serial write wins a same-cycle clash.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (i = 0; i < 9; i = i + 1) begin
        bp_reg[i] <= `DBT_RST_WORD;
      end
      trig_ctrl_reg <= 16'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      for (i = 0; i < 9; i = i + 1) begin
        if (ser_write && ser_idx == i[3:0]) begin
          bp_reg[i] <= ser_wdata;
        end else if (bus_write && bus_idx == i[3:0]) begin
          bp_reg[i] <= avs_writedata;
        end
      end
      if (ser_write && ser_idx == `DBT_IDX_TRIG_CTRL) begin
        trig_ctrl_reg <= ser_wdata[15:0];
      end else if (bus_write && bus_idx == `DBT_IDX_TRIG_CTRL) begin
        trig_ctrl_reg <= avs_writedata[15:0];
      end
      // The interrupt mask is writable from the bus only; serial writes leave it alone.
      if (bus_write && bus_idx == `DBT_IDX_IRQ_MASK) begin
        irq_mask_reg <= avs_writedata[2:0];
      end
    end
  end

  // Comparators and level conditions.
  always @* begin
    addr_hit = cpu_addr_valid & masked_match(cpu_addr, bp_reg[`DBT_IDX_ADDR],
      bp_reg[`DBT_IDX_ADDR_MASK]);
    data_hit = cpu_addr_valid & masked_match(cpu_data, bp_reg[`DBT_IDX_DATA],
      bp_reg[`DBT_IDX_DATA_MASK]);
    pc_hit = 1'b0;
    // Any program-counter register may hit; all of them share one mask.
    for (j = 0; j < NUM_PC; j = j + 1) begin
      if (masked_match(cpu_pc, bp_reg[`DBT_IDX_PC0 + j], bp_reg[`DBT_IDX_PC_MASK])) begin
        pc_hit = cpu_pc_valid;
      end
    end
    lvl1_hit = trig_ctrl_reg[`DBT_TC_ENABLE] &
      level_cond(trig_ctrl_reg[`DBT_TC_LVL1_LO +: 3], addr_hit, data_hit, pc_hit);
    lvl2_hit = trig_ctrl_reg[`DBT_TC_ENABLE] &
      level_cond(trig_ctrl_reg[`DBT_TC_LVL2_LO +: 3], addr_hit, data_hit, pc_hit);
  end

  // Trigger sequencer: single level fires at once, two-level waits for the second.
  always @* begin
    tstate_next = tstate_reg;
    fire = 1'b0;
    case (tstate_reg)
      TS_IDLE: begin
        if (lvl1_hit) begin
          if (trig_ctrl_reg[`DBT_TC_TWO_LEVEL]) begin
            tstate_next = TS_LVL2;
          end else begin
            fire = 1'b1;
          end
        end
      end
      TS_LVL2: begin
        if (!trig_ctrl_reg[`DBT_TC_ENABLE]) begin
          tstate_next = TS_IDLE;
        end else if (lvl2_hit) begin
          fire = 1'b1;
          tstate_next = TS_IDLE;
        end
      end
      default: begin
        tstate_next = TS_IDLE;
      end
    endcase
  end

  // Trigger actions: halt until go, or a debug interrupt that opens emulator mode.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tstate_reg <= TS_IDLE;
      cpu_halt <= 1'b0;
      cpu_debug_irq <= 1'b0;
      emu_reg <= 1'b0;
    end else begin
      tstate_reg <= tstate_next;
      cpu_debug_irq <= fire & trig_ctrl_reg[`DBT_TC_ACTION_IRQ];
      if (fire && !trig_ctrl_reg[`DBT_TC_ACTION_IRQ]) begin
        cpu_halt <= 1'b1;
      end else if (go_cmd) begin
        cpu_halt <= 1'b0;
      end
      if (fire && trig_ctrl_reg[`DBT_TC_ACTION_IRQ]) begin
        emu_reg <= 1'b1;
      end else if (cpu_debug_rte) begin
        emu_reg <= 1'b0;
      end
    end
  end

  // Interrupts at or above the critical level still reach the core in emulator mode.
  assign irq_allow = ~emu_reg |
    (cpu_irq_level >= trig_ctrl_reg[`DBT_TC_CRIT_LO +: 3]);

  // Sticky status, cleared by writing one; a new event wins over the clear.
  always @* begin
    status_next = status_reg;
    if (bus_write && bus_idx == `DBT_IDX_STATUS) begin
      status_next = status_next & ~avs_writedata[2:0];
    end
    if (ser_write && ser_idx == `DBT_IDX_STATUS) begin
      status_next = status_next & ~ser_wdata[2:0];
    end
    // Hardware events are applied last so they win over a same-cycle clear.
    if (fire) begin
      status_next[`DBT_ST_FIRED] = 1'b1;
    end
    if (lvl1_hit) begin
      status_next[`DBT_ST_LVL1] = 1'b1;
    end
    if (ser_write || ser_read) begin
      status_next[`DBT_ST_SERIAL] = 1'b1;
    end
  end

  // Status register, loaded from the combined next value every cycle.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign irq = |(status_reg & irq_mask_reg);

  // Serial channel to the external tool.
  dbt_serial u_serial (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .debug_serial_clock(debug_serial_clock),
    .debug_serial_in(debug_serial_in),
    .debug_serial_out(debug_serial_out),
    .req_write(ser_write),
    .req_read(ser_read),
    .req_idx(ser_idx),
    .req_wdata(ser_wdata),
    .rd_data(ser_rdata)
  );

  // Real-time trace port.
  dbt_trace #(
    .FULL_TRACE(FULL_TRACE)
  ) u_trace (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .cpu_pst(cpu_pst),
    .cpu_debug_trace_data_bus(cpu_debug_trace_data_bus),
    .halted(cpu_halt),
    .processor_status_bus(processor_status_bus),
    .debug_trace_data_bus(debug_trace_data_bus),
    .trace_clock_out(trace_clock_out),
    .all_status_high(all_status_high)
  );

endmodule // dbt_top

// ==== verilog/dbt_trace.v ====
`timescale 1ns/1ps

module dbt_trace #(
  parameter FULL_TRACE = 1
) (
  // Clock and synchronous reset copy.
  input wire sys_clk,
  input wire rst_sync_n,
  // Core status.
  input wire [3:0] cpu_pst,
  input wire [3:0] cpu_debug_trace_data_bus,
  input wire halted,
  // Trace pins.
  output reg [3:0] processor_status_bus,
  output reg [3:0] debug_trace_data_bus,
  output wire trace_clock_out,
  output wire all_status_high
);

  reg [3:0] pst_reg;

  // Status is forced to all ones while halted and registered every cycle.
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pst_reg <= 4'h0;
      processor_status_bus <= 4'h0;
      debug_trace_data_bus <= 4'h0;
    end else begin
      pst_reg <= halted ? 4'hf : cpu_pst;
      processor_status_bus <= (FULL_TRACE != 0) ? (halted ? 4'hf : cpu_pst) : 4'h0;
      debug_trace_data_bus <= (FULL_TRACE != 0) ? cpu_debug_trace_data_bus : 4'h0;
    end
  end

  // Inverted clock puts the trace clock's rising edge mid-way through each beat.
  assign trace_clock_out = (FULL_TRACE != 0) ? ~sys_clk : 1'b0;
  // All-status follows the internal status copy, present on every package.
  assign all_status_high = &pst_reg;

endmodule // dbt_trace
